// [logic/nvec_pkg.sv]
// package for the event counter block: register map, control field positions, reset values
// assumes an 8-bit register port with byte offsets as printed
package nvec_pkg;
	localparam logic [7:0] CTRL_ADDR      = 8'h0d;
	localparam logic [7:0] COUNT_LO_ADDR  = 8'h0e;
	localparam logic [7:0] COUNT_HI_ADDR  = 8'h0f;
	localparam int         STORE_SEL_BIT  = 7;
	localparam int         SNAP_BIT       = 3;
	localparam int         UNLOCK_BIT     = 2;
	localparam int         POLARITY_BIT   = 0;
	localparam logic [7:0] CTRL_RESET     = 8'h00;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic [7:0] UNMAPPED_READ  = 8'h00;
	localparam int         SYNC_STAGES    = 2;
endpackage

// [logic/nvec_edge_detect.sv]
// two-flop synchroniser and edge detector for the count input pin
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/1ps
module nvec_edge_detect (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic srst,
	// pin and selection
	input  wire logic countInputPin,
	input  wire logic risingSel,
	// detected edge
	output logic      edgeSeen
);
	import nvec_pkg::*;

	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       prev;
		logic       edgeSeen;
		logic [1:0] fill;
	} nvec_ed_state_type;

	nvec_ed_state_type st_q;
	nvec_ed_state_type st_d;

	always_comb begin
		st_d = st_q;
		st_d.sync1 = countInputPin;
		st_d.sync2 = st_q.sync1;
		st_d.prev = st_q.sync2;
		// only the second stage and its delayed copy are compared
		// history refills after reset; the cleared flops must not fake an edge on a high pin
		st_d.fill = (st_q.fill == 2'(SYNC_STAGES + 1)) ? st_q.fill : st_q.fill + 2'h1;
		st_d.edgeSeen = 1'b0;
		if (st_q.fill == 2'(SYNC_STAGES + 1)) begin
			st_d.edgeSeen = risingSel ? (st_q.sync2 & ~st_q.prev) : (~st_q.sync2 & st_q.prev);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign edgeSeen = st_q.edgeSeen;
endmodule

// [logic/nvec_event_counter.sv]
// event counter top: 16-bit count on pin edges, control and count byte registers
// assumes a single-cycle register port; storage mode is reported but not modelled electrically
//
// Contract
// - count rises by one on each chosen edge of the count pin
// - storage-select bit picks nonvolatile or battery-backed keeping; bytes stay read/write
// - writing one to snapshot bit latches both bytes together; bit self-clears
// - while unlock bit is one, writes to count bytes load the counter
// - while unlock bit is one, pin edges are ignored
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module nvec_event_counter (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       srst,
	// register port
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrStrobe,
	input  wire logic       regRdStrobe,
	output logic      [7:0] regRdData,
	// pin and status
	input  wire logic       countInputPin,
	output logic            storageSelect,
	output logic            countBlocked
);
	import nvec_pkg::*;

	typedef struct packed {
		logic [15:0] eventCount;
		logic [15:0] snapshot;
		logic        storageSelect;
		logic        writeUnlock;
		logic        edgePolarity;
		logic        pollBit;
		logic [7:0]  rdData;
	} nvec_state_type;

	nvec_state_type st_q;
	nvec_state_type st_d;
	logic           edgeSeen;

	nvec_edge_detect u_edge (
		.sys_clk       (sys_clk),
		.srst          (srst),
		.countInputPin (countInputPin),
		.risingSel     (st_q.edgePolarity),
		.edgeSeen      (edgeSeen)
	);

	always_comb begin
		logic ctrlWr;
		logic loWr;
		logic hiWr;
		ctrlWr = regWrStrobe && (regAddr == CTRL_ADDR);
		loWr = regWrStrobe && (regAddr == COUNT_LO_ADDR);
		hiWr = regWrStrobe && (regAddr == COUNT_HI_ADDR);
		st_d = st_q;
		st_d.rdData = UNMAPPED_READ;
		// counting, gated by unlock
		if (edgeSeen && !st_q.writeUnlock) begin
			st_d.eventCount = st_q.eventCount + 16'h0001;
		end
		// host load of count bytes only when unlocked
		if (st_q.writeUnlock && loWr) begin
			st_d.eventCount[7:0] = regWrData;
		end
		if (st_q.writeUnlock && hiWr) begin
			st_d.eventCount[15:8] = regWrData;
		end
		if (ctrlWr) begin
			st_d.storageSelect = regWrData[STORE_SEL_BIT];
			st_d.writeUnlock = regWrData[UNLOCK_BIT];
			st_d.edgePolarity = regWrData[POLARITY_BIT];
			st_d.pollBit = regWrData[1];
			// snapshot takes the live count; bit reads back zero
			if (regWrData[SNAP_BIT]) begin
				st_d.snapshot = st_q.eventCount;
			end
		end
		if (regRdStrobe) begin
			case (regAddr)
				CTRL_ADDR: begin
					st_d.rdData = {st_q.storageSelect, 3'h0, 1'b0, st_q.writeUnlock,
						st_q.pollBit, st_q.edgePolarity};
				end
				// unlocked: read live count; locked: read snapshot
				COUNT_LO_ADDR: begin
					st_d.rdData = st_q.writeUnlock ? st_q.eventCount[7:0] : st_q.snapshot[7:0];
				end
				COUNT_HI_ADDR: begin
					st_d.rdData = st_q.writeUnlock ? st_q.eventCount[15:8] : st_q.snapshot[15:8];
				end
				default: begin
					st_d.rdData = UNMAPPED_READ;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q.eventCount <= COUNT_RESET;
			st_q.snapshot <= COUNT_RESET;
			st_q.storageSelect <= CTRL_RESET[STORE_SEL_BIT];
			st_q.writeUnlock <= CTRL_RESET[UNLOCK_BIT];
			st_q.edgePolarity <= CTRL_RESET[POLARITY_BIT];
			st_q.pollBit <= 1'b0;
			st_q.rdData <= UNMAPPED_READ;
		end else begin
			st_q <= st_d;
		end
	end

	assign regRdData = st_q.rdData;
	assign storageSelect = st_q.storageSelect;
	assign countBlocked = st_q.writeUnlock;
endmodule

// [sim/nvec_event_counter_assertions.sv]
// checker on the counter ports
// bound to every counter instance
`timescale 1ns/1ps
module nvec_event_counter_assertions (
	// watched ports
	input wire logic       sys_clk,
	input wire logic       srst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrStrobe,
	input wire logic       regRdStrobe,
	input wire logic [7:0] regRdData,
	input wire logic       storageSelect,
	input wire logic       countBlocked
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	wire logic ctlWr = regWrStrobe && regAddr == 8'h0d;
	wire logic ctlRd = regRdStrobe && regAddr == 8'h0d;
	store_sel_a: assert property (ctlWr |=> storageSelect == $past(regWrData[7])) else $error("sel");
	lock_set_a: assert property (ctlWr |=> countBlocked == $past(regWrData[2])) else $error("lock");
	lock_hold_a: assert property (!ctlWr |=> $stable(countBlocked)) else $error("lock moved");
	snap_clear_a: assert property (ctlRd |=> !regRdData[3]) else $error("snap");
	pol_read_a: assert property (ctlWr ##1 ctlRd |=> regRdData[0] == $past(regWrData[0], 2)) else $error("pol");
	count_load_a: assert property (countBlocked && regWrStrobe && regAddr == 8'h0f ##1 regRdStrobe && regAddr == 8'h0f
		|=> regRdData == $past(regWrData, 2)) else $error("load");
	cover property (ctlWr ##1 ctlRd);
	cover property (countBlocked && regWrStrobe);
	cover property (storageSelect);
endmodule
bind nvec_event_counter nvec_event_counter_assertions chk (.*);

// [sim/nvec_event_src.sv]
// source model for the count pin
// assumes lvl and lag come from the bench
`timescale 1ns/1ps
module nvec_event_src (
	// control
	input  wire logic       sys_clk,
	input  wire logic       lvl,
	input  wire logic [1:0] lag,
	// pin
	output logic            pin = 1'h0
);
	logic [3:0] hist_q = 4'h0;
	always_ff @(posedge sys_clk) begin
		hist_q <= {hist_q[2:0], lvl};
		pin <= hist_q[lag];
	end
endmodule

// [sim/nvec_event_counter_tb.sv]
// bench for the event counter
// assumes the source model drives the pin
`timescale 1ns/1ps
module nvec_event_counter_tb;
	import nvec_pkg::*;
	logic sys_clk = 0, srst = 1, wr = 0, rd = 0, lvl = 0, pin, sel, blk;
	logic [7:0] addr = 0, wd = 0, rdat, lo, hi, ctl;
	logic [1:0] lag = 0;
	logic [15:0] cnt = 0;
	int err_total = 0, cmp_count = 0;
	nvec_event_src src (.sys_clk(sys_clk), .lvl(lvl), .lag(lag), .pin(pin));
	nvec_event_counter dut (.sys_clk(sys_clk), .srst(srst), .regAddr(addr), .regWrData(wd), .regWrStrobe(wr),
		.regRdStrobe(rd), .regRdData(rdat), .countInputPin(pin), .storageSelect(sel), .countBlocked(blk));
	task automatic chk(string n, logic [15:0] s, e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic w(logic [7:0] a, d);
		addr <= a; wd <= d; wr <= 1; rd <= 0;
		@(posedge sys_clk);
	endtask
	task automatic r(logic [7:0] a, output logic [7:0] d);
		addr <= a; rd <= 1; wr <= 0;
		@(posedge sys_clk);
		rd <= 0;
		@(posedge sys_clk);
		d = rdat;
	endtask
	task automatic step(logic v, lock);
		if (v != lvl && v == ctl[0] && !lock) cnt++;
		lvl <= v; wr <= 0;
		repeat (12) @(posedge sys_clk);
	endtask
	task final_report;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial forever #2 sys_clk = ~sys_clk;
	initial begin
		void'($urandom(12195));
		repeat (4) @(posedge sys_clk);
		srst <= 0;
		for (int i = 0; i < 12; i++) begin
			ctl = 8'($urandom) & 8'h81;
			lag <= 2'($urandom);
			w(CTRL_ADDR, ctl);
			repeat (6) step(1'($urandom), 0);
			if (i % 3 == 2) begin
				w(CTRL_ADDR, ctl | 8'h04);
				cnt = 16'($urandom);
				w(COUNT_LO_ADDR, cnt[7:0]);
				w(COUNT_HI_ADDR, cnt[15:8]);
				r(COUNT_HI_ADDR, hi);
				chk("load", 16'(hi), 16'(cnt[15:8]));
				chk("blocked", 16'(blk), 16'h0001);
				step(!lvl, 1);
				chk("blocked", 16'(blk), 16'h0001);
				w(CTRL_ADDR, ctl);
				w(COUNT_LO_ADDR, 8'($urandom));
				chk("unblocked", 16'(blk), 16'h0000);
			end
			w(CTRL_ADDR, ctl | 8'h08);
			r(CTRL_ADDR, lo);
			chk("ctrl", 16'(lo), 16'(ctl));
			chk("sel", 16'(sel), 16'(ctl[7]));
			r(COUNT_LO_ADDR, lo);
			r(COUNT_HI_ADDR, hi);
			chk("count", {hi, lo}, cnt);
			$display("test %0d done", i);
		end
		final_report;
	end
endmodule
